/* design/ramped_pulse_train_generator.sv */
// Design decisions made here: the Avalon-MM interface to the registers and the register offsets.
`timescale 1ns/100ps
// How it works
// - Start trigger begins train with loaded settings
// - Enable low halts output at once
// - Start width opens acceleration, 10 us units
// - Acceleration lasts the programmed pulse count
// - Run width sets constant speed, 10 us
// - Deceleration lasts the programmed pulse count
// - Total count covers all three phases
// - Width steps linearly between phase widths
// - Zero ramp count skips that phase
// - Channel select routes train to output
// - Done low at start, high when finished
// - Done may chain into another generator
// - Inactive until option set then soft reset
module ramped_pulse_train_generator (
	// Clock and reset
	input  wire logic        ref_clk_i,
	input  wire logic        rstn_i,
	// Avalon-MM slave
	input  wire logic [5:0]  address_i,
	input  wire logic        read_i,
	input  wire logic        write_i,
	input  wire logic [31:0] writedata_i,
	input  wire logic [3:0]  byteenable_i,
	output logic      [31:0] readdata_o,
	output logic             waitrequest_o,
	// Controlling logic
	input  wire logic        start_i,
	input  wire logic        enable_i,
	// Pulse outputs and status
	output logic      [3:0]  digital_out_o,
	output logic             train_done_o,
	output logic             irq_o
);

	logic [15:0] start_width;
	logic [15:0] accel_count;
	logic [15:0] run_width;
	logic [15:0] stop_width;
	logic [15:0] decel_count;
	logic [31:0] total_count;
	logic [1:0]  channel_sel;
	logic [1:0]  channel_run;
	logic        pulse_out_cfg;
	logic        active;
	localparam int IRQ_W_L = pulse_train_pkg::IRQ_W;
	logic [IRQ_W_L-1:0] irq_enable;
	logic [IRQ_W_L-1:0] irq_status;

	pulse_train_pkg::train_state_t state;
	pulse_train_pkg::train_state_t next_state;
	pulse_train_pkg::phase_t       phase;

	logic        start_prev;
	logic [9:0]  prescale;
	logic [15:0] unit_cnt;
	logic [15:0] pulse_width;
	logic [31:0] pulse_cnt;
	logic [15:0] ramp_width;

	function automatic logic [31:0] apply_be(input logic [31:0] old, input logic [31:0] wd, input logic [3:0] be);
		for (int i = 0; i < 4; i++) begin
			if (be[i]) begin
				old[i*8 +: 8] = wd[i*8 +: 8];
			end
		end
		apply_be = old;
	endfunction

	// Byte-lane merge for the 16-bit settings
	function automatic logic [15:0] be16(input logic [15:0] old, input logic [31:0] wd, input logic [3:0] be);
		be16 = {be[1] ? wd[15:8] : old[15:8], be[0] ? wd[7:0] : old[7:0]};
	endfunction

	// A zero width is run as one unit rather than stalling the train
	function automatic logic [15:0] eff_width(input logic [15:0] w);
		eff_width = (w == 16'h0000) ? 16'h0001 : w;
	endfunction

	// Bus decode
	logic        wr_go;
	logic        sw_start;
	logic        soft_rst;
	assign wr_go    = write_i & ~waitrequest_o;
	assign sw_start = wr_go && address_i == pulse_train_pkg::REG_CTRL && byteenable_i[0] &&
		writedata_i[pulse_train_pkg::CTRL_START_BIT];
	assign soft_rst = wr_go && address_i == pulse_train_pkg::REG_CTRL && byteenable_i[0] &&
		writedata_i[pulse_train_pkg::CTRL_SRESET_BIT];

	// Train control terms
	logic        start_trig;
	logic        can_start;
	logic        begin_train;
	logic        halt;
	logic        half_tick;
	logic        phase_end;
	logic        last_pulse;
	logic        pulse_start;
	logic        finish;
	logic [31:0] next_idx;
	logic [31:0] decel_first;
	logic        decel_load;
	logic        accel_load;
	logic [15:0] first_width;

	assign start_trig  = (start_i & ~start_prev) | sw_start;
	assign can_start   = active & enable_i & (state == pulse_train_pkg::ST_IDLE) & ~soft_rst;
	assign begin_train = start_trig & can_start;
	assign halt        = ~enable_i | soft_rst;
	assign half_tick   = prescale == pulse_train_pkg::HALF_LAST;
	assign phase_end   = half_tick && unit_cnt == eff_width(pulse_width) - 16'h0001;
	assign last_pulse  = pulse_cnt + 32'h1 == total_count;
	assign finish      = state == pulse_train_pkg::ST_LOW && phase_end && last_pulse && ~halt;
	assign pulse_start = (state == pulse_train_pkg::ST_IDLE && begin_train && total_count != 32'h0) ||
		(state == pulse_train_pkg::ST_LOW && phase_end && ~last_pulse && ~halt);
	assign next_idx    = (state == pulse_train_pkg::ST_IDLE) ? 32'h0 : pulse_cnt + 32'h1;
	assign decel_first = total_count - {16'h0000, decel_count};
	assign first_width = (accel_count != 16'h0000) ? start_width : run_width;
	// Decel ramp loads one pulse early so its last pulse lands on the stop width
	assign decel_load  = pulse_start && decel_count != 16'h0000 &&
		(next_idx + 32'h1 == decel_first || (next_idx == 32'h0 && {16'h0000, decel_count} >= total_count));
	assign accel_load  = pulse_start && next_idx == 32'h0 && ~decel_load;

	width_ramp_stepper u_ramp (
		.ref_clk_i (ref_clk_i),
		.rstn_i    (rstn_i),
		.load_i    (decel_load | accel_load),
		.step_i    (pulse_start),
		.from_i    (decel_load ? run_width : first_width),
		.to_i      (decel_load ? stop_width : run_width),
		.span_i    (decel_load ? decel_count : accel_count),
		.width_o   (ramp_width)
	);

	always_comb begin
		next_state = state;
		unique case (state)
			pulse_train_pkg::ST_IDLE: begin
				if (begin_train && total_count != 32'h0) begin
					next_state = pulse_train_pkg::ST_HIGH;
				end
			end
			pulse_train_pkg::ST_HIGH: begin
				if (halt) begin
					next_state = pulse_train_pkg::ST_IDLE;
				end else if (phase_end) begin
					next_state = pulse_train_pkg::ST_LOW;
				end
			end
			pulse_train_pkg::ST_LOW: begin
				if (halt) begin
					next_state = pulse_train_pkg::ST_IDLE;
				end else if (phase_end) begin
					next_state = last_pulse ? pulse_train_pkg::ST_IDLE : pulse_train_pkg::ST_HIGH;
				end
			end
			default: next_state = pulse_train_pkg::ST_IDLE;
		endcase
	end

	always_comb begin
		if (pulse_cnt < {16'h0000, accel_count}) begin
			phase = pulse_train_pkg::PH_ACCEL;
		end else if (decel_count != 16'h0000 && pulse_cnt >= decel_first) begin
			phase = pulse_train_pkg::PH_DECEL;
		end else begin
			phase = pulse_train_pkg::PH_RUN;
		end
	end

	always_ff @(posedge ref_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			state      <= pulse_train_pkg::ST_IDLE;
			start_prev <= 1'b0;
		end else begin
			state      <= next_state;
			start_prev <= start_i;
		end
	end

	// Half-unit prescaler and unit counter time both halves of a pulse
	always_ff @(posedge ref_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			prescale <= 10'h000;
			unit_cnt <= 16'h0000;
		end else if (state == pulse_train_pkg::ST_IDLE || halt) begin
			prescale <= 10'h000;
			unit_cnt <= 16'h0000;
		end else if (half_tick) begin
			prescale <= 10'h000;
			unit_cnt <= phase_end ? 16'h0000 : unit_cnt + 16'h0001;
		end else begin
			prescale <= prescale + 10'h001;
		end
	end

	always_ff @(posedge ref_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			pulse_width <= pulse_train_pkg::WIDTH_RESET;
			pulse_cnt   <= 32'h0000_0000;
			channel_run <= 2'b00;
		end else if (begin_train) begin
			pulse_width <= first_width;
			pulse_cnt   <= 32'h0000_0000;
			channel_run <= channel_sel;
		end else begin
			if (pulse_start) begin
				pulse_width <= ramp_width;
			end
			if (state == pulse_train_pkg::ST_LOW && phase_end && ~halt) begin
				pulse_cnt <= pulse_cnt + 32'h1;
			end
		end
	end

	always_ff @(posedge ref_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			train_done_o  <= 1'b0;
			digital_out_o <= 4'h0;
		end else begin
			if (begin_train) begin
				train_done_o <= (total_count == 32'h0);
			end else if (finish) begin
				train_done_o <= 1'b1;
			end
			if (next_state == pulse_train_pkg::ST_HIGH) begin
				digital_out_o <= 4'h1 << ((state == pulse_train_pkg::ST_IDLE) ? channel_sel : channel_run);
			end else begin
				digital_out_o <= 4'h0;
			end
		end
	end

	// Settings; the option only takes hold at a soft reset
	always_ff @(posedge ref_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			start_width   <= pulse_train_pkg::WIDTH_RESET;
			accel_count   <= pulse_train_pkg::COUNT_RESET;
			run_width     <= pulse_train_pkg::WIDTH_RESET;
			stop_width    <= pulse_train_pkg::WIDTH_RESET;
			decel_count   <= pulse_train_pkg::COUNT_RESET;
			total_count   <= pulse_train_pkg::TOTAL_RESET;
			channel_sel   <= 2'b00;
			pulse_out_cfg <= 1'b0;
			active        <= 1'b0;
			irq_enable    <= '0;
		end else begin
			if (soft_rst) begin
				active <= pulse_out_cfg;
			end
			if (wr_go) begin
				unique case (address_i)
					pulse_train_pkg::REG_START_WIDTH: start_width <= be16(start_width, writedata_i, byteenable_i);
					pulse_train_pkg::REG_ACCEL_COUNT: accel_count <= be16(accel_count, writedata_i, byteenable_i);
					pulse_train_pkg::REG_RUN_WIDTH:   run_width   <= be16(run_width, writedata_i, byteenable_i);
					pulse_train_pkg::REG_STOP_WIDTH:  stop_width  <= be16(stop_width, writedata_i, byteenable_i);
					pulse_train_pkg::REG_DECEL_COUNT: decel_count <= be16(decel_count, writedata_i, byteenable_i);
					pulse_train_pkg::REG_TOTAL_COUNT: total_count <= apply_be(total_count, writedata_i, byteenable_i);
					pulse_train_pkg::REG_CHANNEL:     if (byteenable_i[0]) channel_sel <= writedata_i[1:0];
					pulse_train_pkg::REG_CONFIG:      if (byteenable_i[0]) pulse_out_cfg <= writedata_i[pulse_train_pkg::CONFIG_PTO_BIT];
					pulse_train_pkg::REG_IRQ_ENABLE:  if (byteenable_i[0]) irq_enable <= writedata_i[IRQ_W_L-1:0];
					default: ;
				endcase
			end
		end
	end

	// Interrupts: a new event wins over a clear in the same cycle
	logic [IRQ_W_L-1:0] events;
	logic [IRQ_W_L-1:0] clr_mask;
	always_comb begin
		events = '0;
		events[pulse_train_pkg::IRQ_DONE_BIT]    = finish | (begin_train & total_count == 32'h0);
		events[pulse_train_pkg::IRQ_ABORT_BIT]   = halt & (state != pulse_train_pkg::ST_IDLE);
		events[pulse_train_pkg::IRQ_REFUSED_BIT] = start_trig & ~can_start;
		clr_mask = (wr_go && address_i == pulse_train_pkg::REG_IRQ_CLEAR && byteenable_i[0]) ?
			writedata_i[IRQ_W_L-1:0] : '0;
	end

	always_ff @(posedge ref_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			irq_status <= '0;
			irq_o      <= 1'b0;
		end else begin
			irq_status <= (irq_status & ~clr_mask) | events;
			irq_o      <= |(((irq_status & ~clr_mask) | events) & irq_enable);
		end
	end

	// Avalon: one wait state, read data registered for the accepting edge
	logic [31:0] read_mux;
	always_comb begin
		read_mux = 32'h0;
		unique case (address_i)
			pulse_train_pkg::REG_START_WIDTH: read_mux = {16'h0, start_width};
			pulse_train_pkg::REG_ACCEL_COUNT: read_mux = {16'h0, accel_count};
			pulse_train_pkg::REG_RUN_WIDTH:   read_mux = {16'h0, run_width};
			pulse_train_pkg::REG_STOP_WIDTH:  read_mux = {16'h0, stop_width};
			pulse_train_pkg::REG_DECEL_COUNT: read_mux = {16'h0, decel_count};
			pulse_train_pkg::REG_TOTAL_COUNT: read_mux = total_count;
			pulse_train_pkg::REG_CHANNEL:     read_mux = {30'h0, channel_sel};
			pulse_train_pkg::REG_CONFIG:      read_mux = {31'h0, pulse_out_cfg};
			pulse_train_pkg::REG_STATUS: begin
				read_mux[pulse_train_pkg::STAT_BUSY_BIT]   = state != pulse_train_pkg::ST_IDLE;
				read_mux[pulse_train_pkg::STAT_DONE_BIT]   = train_done_o;
				read_mux[pulse_train_pkg::STAT_ACTIVE_BIT] = active;
				read_mux[pulse_train_pkg::STAT_PHASE_LSB +: 2] = phase;
				read_mux[pulse_train_pkg::STAT_WIDTH_LSB +: 16] = pulse_width;
			end
			pulse_train_pkg::REG_PULSE_COUNT: read_mux = pulse_cnt;
			pulse_train_pkg::REG_IRQ_STATUS:  read_mux = {29'h0, irq_status};
			pulse_train_pkg::REG_IRQ_ENABLE:  read_mux = {29'h0, irq_enable};
			default: read_mux = 32'h0;
		endcase
	end

	always_ff @(posedge ref_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			waitrequest_o <= 1'b1;
			readdata_o    <= 32'h0;
		end else begin
			waitrequest_o <= ~(waitrequest_o & (read_i | write_i));
			if (read_i && waitrequest_o) begin
				readdata_o <= read_mux;
			end
		end
	end

	// Checks
	logic [31:0] hi_cycles;
	always_ff @(posedge ref_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			hi_cycles <= 32'h0;
		end else begin
			hi_cycles <= (state == pulse_train_pkg::ST_HIGH) ? hi_cycles + 32'h1 : 32'h0;
		end
	end

	default clocking cb @(posedge ref_clk_i); endclocking
	default disable iff (!rstn_i);

	chk_start_begins: assert property (begin_train && total_count != 32'h0 |=> state == pulse_train_pkg::ST_HIGH)
		else $error("start did not begin a train");
	chk_enable_halts: assert property (!enable_i |=> digital_out_o == 4'h0 && state == pulse_train_pkg::ST_IDLE)
		else $error("output not halted with enable low");
	chk_first_width: assert property (begin_train && accel_count != 16'h0 |=> pulse_width == $past(start_width))
		else $error("first pulse not at start width");
	chk_skip_accel: assert property (begin_train && accel_count == 16'h0 |=> pulse_width == $past(run_width))
		else $error("zero accel count did not skip ramp");
	chk_accel_bounds: assert property (state != pulse_train_pkg::ST_IDLE && phase == pulse_train_pkg::PH_ACCEL &&
		start_width <= run_width && 32'(accel_count) + 32'(decel_count) <= total_count
		|-> pulse_width >= start_width && pulse_width <= run_width)
		else $error("accel width outside ramp range");
	chk_total_bound: assert property (state != pulse_train_pkg::ST_IDLE |-> pulse_cnt < total_count)
		else $error("pulse count passed total");
	chk_done_finish: assert property (finish |=> train_done_o && pulse_cnt == $past(total_count) ##1 $stable(train_done_o))
		else $error("done not raised after total pulses");
	chk_done_low: assert property (begin_train && total_count != 32'h0 |=> !train_done_o)
		else $error("done not low during train");
	chk_channel_route: assert property (state == pulse_train_pkg::ST_HIGH |-> digital_out_o == 4'h1 << channel_run)
		else $error("pulse on wrong channel");
	chk_inactive_idle: assert property (!active |-> state == pulse_train_pkg::ST_IDLE)
		else $error("train ran while inactive");
	chk_even_split: assert property (state == pulse_train_pkg::ST_HIGH && phase_end && !halt
		|-> hi_cycles == 32'(eff_width(pulse_width)) * 32'(pulse_train_pkg::HALF_UNIT_CYCLES) - 32'h1
		##1 state == pulse_train_pkg::ST_LOW)
		else $error("high half has wrong length");

	cov_full_train: cover property (finish);
	cov_abort: cover property (halt && state != pulse_train_pkg::ST_IDLE);
	cov_decel_seen: cover property (state == pulse_train_pkg::ST_HIGH && phase == pulse_train_pkg::PH_DECEL);
	cov_refused: cover property (start_trig && !can_start);

endmodule // ramped_pulse_train_generator

/* design/pulse_train_pkg.sv */
package pulse_train_pkg;

	// Avalon register map, byte addresses
	localparam logic [5:0] REG_CTRL        = 6'h00;
	localparam logic [5:0] REG_START_WIDTH = 6'h04;
	localparam logic [5:0] REG_ACCEL_COUNT = 6'h08;
	localparam logic [5:0] REG_RUN_WIDTH   = 6'h0C;
	localparam logic [5:0] REG_STOP_WIDTH  = 6'h10;
	localparam logic [5:0] REG_DECEL_COUNT = 6'h14;
	localparam logic [5:0] REG_TOTAL_COUNT = 6'h18;
	localparam logic [5:0] REG_CHANNEL     = 6'h1C;
	localparam logic [5:0] REG_CONFIG      = 6'h20;
	localparam logic [5:0] REG_STATUS      = 6'h24;
	localparam logic [5:0] REG_PULSE_COUNT = 6'h28;
	localparam logic [5:0] REG_IRQ_STATUS  = 6'h2C;
	localparam logic [5:0] REG_IRQ_CLEAR   = 6'h30;
	localparam logic [5:0] REG_IRQ_ENABLE  = 6'h34;

	// Field positions
	localparam int CTRL_START_BIT  = 0;
	localparam int CTRL_SRESET_BIT = 1;
	localparam int CONFIG_PTO_BIT  = 0;
	localparam int STAT_BUSY_BIT   = 0;
	localparam int STAT_DONE_BIT   = 1;
	localparam int STAT_ACTIVE_BIT = 2;
	localparam int STAT_PHASE_LSB  = 4;
	localparam int STAT_WIDTH_LSB  = 16;
	localparam int IRQ_DONE_BIT    = 0;
	localparam int IRQ_ABORT_BIT   = 1;
	localparam int IRQ_REFUSED_BIT = 2;
	localparam int IRQ_W           = 3;

	// Reset values
	localparam logic [15:0] WIDTH_RESET = 16'h0001;
	localparam logic [15:0] COUNT_RESET = 16'h0000;
	localparam logic [31:0] TOTAL_RESET = 32'h0000_0000;

	// Timing: 10 us width unit at a 10 ns clock
	localparam int CLK_PERIOD_NS    = 10;
	localparam int UNIT_TIME_NS     = 10000;
	localparam int UNIT_CYCLES      = UNIT_TIME_NS / CLK_PERIOD_NS;
	localparam int HALF_UNIT_CYCLES = UNIT_CYCLES / 2;
	localparam logic [9:0] HALF_LAST = 10'(HALF_UNIT_CYCLES - 1);

	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_HIGH = 2'b01,
		ST_LOW  = 2'b10
	} train_state_t;

	typedef enum logic [1:0] {
		PH_ACCEL = 2'b00,
		PH_RUN   = 2'b01,
		PH_DECEL = 2'b10
	} phase_t;

endpackage

/* design/width_ramp_stepper.sv */
`timescale 1ns/100ps
module width_ramp_stepper (
	// Clock and reset
	input  wire logic        ref_clk_i,
	input  wire logic        rstn_i,
	// Ramp control
	input  wire logic        load_i,
	input  wire logic        step_i,
	input  wire logic [15:0] from_i,
	input  wire logic [15:0] to_i,
	input  wire logic [15:0] span_i,
	// Current width
	output logic      [15:0] width_o
);

	logic [15:0] target;
	logic [15:0] span;
	logic [15:0] delta;
	logic [31:0] err;

	function automatic logic [15:0] abs_diff(input logic [15:0] a, input logic [15:0] b);
		abs_diff = (a > b) ? (a - b) : (b - a);
	endfunction

	// Bresenham walk: k pulses give floor(k*delta/span) unit steps.
	// One unit step per clock; a huge delta over a short span lags.
	always_ff @(posedge ref_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			width_o <= pulse_train_pkg::WIDTH_RESET;
			target  <= pulse_train_pkg::WIDTH_RESET;
			span    <= pulse_train_pkg::COUNT_RESET;
			delta   <= 16'h0000;
			err     <= 32'h0000_0000;
		end else if (load_i) begin
			// Load counts as the first step so the next pulse is already one step in
			width_o <= (span_i == 16'h0000) ? to_i : from_i;
			target  <= to_i;
			span    <= span_i;
			delta   <= abs_diff(from_i, to_i);
			err     <= {16'h0000, abs_diff(from_i, to_i)};
		end else if (step_i) begin
			err <= err + {16'h0000, delta};
		end else if (width_o != target && span != 16'h0000 && err >= {16'h0000, span}) begin
			width_o <= (target > width_o) ? (width_o + 16'h0001) : (width_o - 16'h0001);
			err     <= err - {16'h0000, span};
		end
	end

endmodule // width_ramp_stepper

/* verif/stepper_drive_model.sv */
`timescale 1ns/100ps
module stepper_drive_model (
	// Clock and reset
	input  wire logic        ref_clk_i,
	input  wire logic        rstn_i,
	// Measurement control
	input  wire logic        clear_i,
	// Step inputs of the drive
	input  wire logic [3:0]  step_i,
	// Measured train
	output logic      [15:0] pulses_o,
	output logic      [31:0] first_high_o,
	output logic      [31:0] last_high_o,
	output logic      [3:0]  seen_o
);
	logic        prev;
	logic [31:0] run_len;

	// Any channel counts, so a misrouted train is still seen
	always_ff @(posedge ref_clk_i or negedge rstn_i) begin
		if (!rstn_i || clear_i) begin
			prev         <= 1'b0;
			run_len      <= 32'h0;
			pulses_o     <= 16'h0;
			first_high_o <= 32'h0;
			last_high_o  <= 32'h0;
			seen_o       <= 4'h0;
		end else begin
			prev   <= |step_i;
			seen_o <= seen_o | step_i;
			if (|step_i)
				run_len <= run_len + 32'h1;
			if (|step_i && !prev) begin
				pulses_o <= pulses_o + 16'h1;
				run_len  <= 32'h1;
			end
			if (!(|step_i) && prev) begin
				last_high_o <= run_len;
				if (pulses_o == 16'h1)
					first_high_o <= run_len;
			end
		end
	end
endmodule // stepper_drive_model

/* verif/ramped_pulse_train_generator_tb.sv */
`timescale 1ns/100ps
`define CHK(a, e) begin num_checks++; if ((a) !== (e)) begin mismatches++; \
	$display("wrong value at %0t: got %h expected %h", $time, (a), (e)); end end
module ramped_pulse_train_generator_tb;
	logic        ref_clk_i = 1'b0;
	logic        rstn_i    = 1'b0;
	logic [5:0]  address   = 6'h00;
	logic        read      = 1'b0;
	logic        write     = 1'b0;
	logic [31:0] writedata = 32'h0;
	logic [31:0] readdata;
	logic        waitrequest;
	logic        start     = 1'b0;
	logic        enable    = 1'b1;
	logic [3:0]  dout;
	logic        done;
	logic        irq;
	logic        clear     = 1'b0;
	logic [15:0] pulses;
	logic [31:0] first_high;
	logic [31:0] last_high;
	logic [3:0]  seen;
	logic [31:0] rd;
	int          mismatches = 0;
	int          num_checks = 0;
	// Settings in register order, then expected first and last high time
	logic [5:0]  cfg_addr [7] = '{pulse_train_pkg::REG_START_WIDTH, pulse_train_pkg::REG_ACCEL_COUNT,
		pulse_train_pkg::REG_RUN_WIDTH, pulse_train_pkg::REG_STOP_WIDTH, pulse_train_pkg::REG_DECEL_COUNT,
		pulse_train_pkg::REG_TOTAL_COUNT, pulse_train_pkg::REG_CHANNEL};
	logic [31:0] rows [4][9] = '{
		'{32'h2, 32'h1, 32'h1, 32'h3, 32'h1, 32'h3, 32'h0, 32'h3E8, 32'h5DC},
		'{32'h1, 32'h0, 32'h1, 32'h1, 32'h0, 32'h2, 32'h1, 32'h1F4, 32'h1F4},
		'{32'h3, 32'h2, 32'h1, 32'h1, 32'h0, 32'h3, 32'h2, 32'h5DC, 32'h1F4},
		'{32'h5, 32'h0, 32'h2, 32'h2, 32'h0, 32'h1, 32'h3, 32'h3E8, 32'h3E8}};

	always #5 ref_clk_i = ~ref_clk_i;

	ramped_pulse_train_generator DUT (
		.ref_clk_i     (ref_clk_i),
		.rstn_i        (rstn_i),
		.address_i     (address),
		.read_i        (read),
		.write_i       (write),
		.writedata_i   (writedata),
		.byteenable_i  (4'hF),
		.readdata_o    (readdata),
		.waitrequest_o (waitrequest),
		.start_i       (start),
		.enable_i      (enable),
		.digital_out_o (dout),
		.train_done_o  (done),
		.irq_o         (irq)
	);

	stepper_drive_model drive (
		.ref_clk_i    (ref_clk_i),
		.rstn_i       (rstn_i),
		.clear_i      (clear),
		.step_i       (dout),
		.pulses_o     (pulses),
		.first_high_o (first_high),
		.last_high_o  (last_high),
		.seen_o       (seen)
	);

	// Registered outputs: the value read just after an edge is the one that edge sampled
	task automatic bus_rw(input logic wr, input logic [5:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge ref_clk_i);
		address   <= a;
		writedata <= d;
		write     <= wr;
		read      <= !wr;
		do begin
			@(posedge ref_clk_i);
			n++;
		end while (waitrequest !== 1'b0 && n < 50);
		rd = readdata;
		write <= 1'b0;
		read  <= 1'b0;
		if (n >= 50)
			mismatches++;
	endtask

	task automatic chk_rd(input logic [5:0] a, input logic [31:0] e);
		bus_rw(1'b0, a, 32'h0);
		`CHK(rd, e)
	endtask

	task automatic trig();
		@(posedge ref_clk_i);
		clear <= 1'b1;
		@(posedge ref_clk_i);
		clear <= 1'b0;
		start <= 1'b1;
		repeat (3) @(posedge ref_clk_i);
		start <= 1'b0;
	endtask

	task automatic wait_done();
		int n;
		n = 0;
		while (done !== 1'b1 && n < 20000) begin
			@(posedge ref_clk_i);
			n++;
		end
		`CHK(done, 1'b1)
		repeat (2) @(posedge ref_clk_i);
	endtask

	task automatic summarize();
		$display("checks %0d mismatches %0d", num_checks, mismatches);
		if (mismatches == 0 && num_checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	initial begin
		repeat (90000) @(posedge ref_clk_i);
		mismatches++;
		summarize();
	end

	initial begin
		repeat (6) @(posedge ref_clk_i);
		rstn_i <= 1'b1;
		@(posedge ref_clk_i);
		`CHK({done, irq, dout}, 6'h00)
		chk_rd(pulse_train_pkg::REG_START_WIDTH, 32'h1);
		chk_rd(pulse_train_pkg::REG_TOTAL_COUNT, 32'h0);
		bus_rw(1'b1, 6'h3C, 32'hFFFF_FFFF);
		chk_rd(6'h3C, 32'h0);
		// Not yet activated: trigger must be refused
		trig();
		repeat (20) @(posedge ref_clk_i);
		`CHK(pulses, 16'h0)
		chk_rd(pulse_train_pkg::REG_IRQ_STATUS, 32'h4);
		bus_rw(1'b1, pulse_train_pkg::REG_IRQ_CLEAR, 32'h7);
		bus_rw(1'b1, pulse_train_pkg::REG_CONFIG, 32'h1);
		bus_rw(1'b1, pulse_train_pkg::REG_CTRL, 32'h2);
		bus_rw(1'b0, pulse_train_pkg::REG_STATUS, 32'h0);
		`CHK(rd[2], 1'b1)
		bus_rw(1'b1, pulse_train_pkg::REG_IRQ_ENABLE, 32'h1);
		for (int i = 0; i < 4; i++) begin
			for (int k = 0; k < 7; k++)
				bus_rw(1'b1, cfg_addr[k], rows[i][k]);
			trig();
			`CHK(done, 1'b0)
			wait_done();
			`CHK(pulses, rows[i][5][15:0])
			`CHK(first_high, rows[i][7])
			`CHK(last_high, rows[i][8])
			`CHK(seen, 4'h1 << rows[i][6][1:0])
			`CHK(irq, 1'b1)
			chk_rd(pulse_train_pkg::REG_PULSE_COUNT, rows[i][5]);
			bus_rw(1'b1, pulse_train_pkg::REG_IRQ_CLEAR, 32'h1);
			repeat (2) @(posedge ref_clk_i);
			`CHK(irq, 1'b0)
		end
		// Masked interrupt, empty train finishes at once
		bus_rw(1'b1, pulse_train_pkg::REG_IRQ_ENABLE, 32'h0);
		bus_rw(1'b1, pulse_train_pkg::REG_TOTAL_COUNT, 32'h0);
		trig();
		wait_done();
		`CHK({irq, pulses}, 17'h0)
		chk_rd(pulse_train_pkg::REG_IRQ_STATUS, 32'h1);
		bus_rw(1'b1, pulse_train_pkg::REG_IRQ_CLEAR, 32'h7);
		// Emergency stop in the middle of a pulse
		bus_rw(1'b1, pulse_train_pkg::REG_TOTAL_COUNT, 32'h5);
		trig();
		repeat (300) @(posedge ref_clk_i);
		enable <= 1'b0;
		repeat (3) @(posedge ref_clk_i);
		`CHK(dout, 4'h0)
		repeat (1500) @(posedge ref_clk_i);
		`CHK({done, pulses}, 17'h1)
		chk_rd(pulse_train_pkg::REG_IRQ_STATUS, 32'h2);
		bus_rw(1'b1, pulse_train_pkg::REG_IRQ_CLEAR, 32'h7);
		enable <= 1'b1;
		// Second trigger while busy is refused and does not restart
		bus_rw(1'b1, pulse_train_pkg::REG_TOTAL_COUNT, 32'h2);
		trig();
		repeat (100) @(posedge ref_clk_i);
		start <= 1'b1;
		repeat (3) @(posedge ref_clk_i);
		start <= 1'b0;
		wait_done();
		`CHK(pulses, 16'h2)
		chk_rd(pulse_train_pkg::REG_IRQ_STATUS, 32'h5);
		summarize();
	end
endmodule // ramped_pulse_train_generator_tb
